/* logic/ciw_window_ctrl.sv */
// Per-socket window enables, access claim and I/O cycle width and timing
`timescale 1ns/1ps
`default_nettype none

module ciw_window_ctrl (
	input wire logic i_clock, // System clock, 20 MHz
	input wire logic i_rstn, // Asynchronous reset, active low
	input wire logic i_reg_wr, // Register write strobe
	input wire logic i_reg_rd, // Register read strobe
	input wire logic [7:0] i_reg_addr, // Register offset
	input wire logic [7:0] i_reg_wdata, // Register write data
	output logic [7:0] o_reg_rdata, // Register read data, held until next read
	input wire logic i_host_req, // One-cycle pulse: host cycle to card space
	input wire logic i_host_is_io, // Request is an I/O cycle, else memory
	input wire logic [4:0] i_mem_hit, // Address falls in memory window n
	input wire logic [1:0] i_io_hit, // Address falls in I/O window n
	output logic o_claim, // Cycle claimed, high until the access ends
	output logic o_host_done, // One-cycle pulse: access complete
	output logic o_io_win_sel, // I/O window taken by the current access
	output logic [4:0] o_mem_win_on, // Memory window enables
	output logic [1:0] o_io_win_on, // I/O window enables
	input wire logic i_card_io_wide_indication_n, // Card 16-bit I/O pin, active low
	output logic o_card_strobe_n, // Card access strobe, active low
	output logic o_card_is_io, // Current card access is I/O
	output logic o_card_wide // Current I/O access is 16 bits
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0] win_en_q;
	logic [7:0] win_en_d;
	logic [7:0] io_ctrl_q;
	logic [7:0] io_ctrl_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	always_comb begin
		win_en_d = win_en_q;
		io_ctrl_d = io_ctrl_q;
		rdata_d = rdata_q;
		if (i_reg_wr && (i_reg_addr == ciw_pkg::OFS_WINDOW_ENABLE)) begin
			win_en_d = i_reg_wdata & ciw_pkg::WINDOW_ENABLE_WMASK;
		end
		if (i_reg_wr && (i_reg_addr == ciw_pkg::OFS_IO_WINDOW_CONTROL)) begin
			io_ctrl_d = i_reg_wdata;
		end
		if (i_reg_rd) begin
			case (i_reg_addr)
				ciw_pkg::OFS_WINDOW_ENABLE: begin
					rdata_d = win_en_q & ciw_pkg::WINDOW_ENABLE_WMASK;
				end
				ciw_pkg::OFS_IO_WINDOW_CONTROL: begin
					rdata_d = io_ctrl_q;
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			win_en_q <= ciw_pkg::WINDOW_ENABLE_RESET;
			io_ctrl_q <= ciw_pkg::IO_WINDOW_CONTROL_RESET;
			rdata_q <= 8'h00;
		end else begin
			win_en_q <= win_en_d;
			io_ctrl_q <= io_ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Window enables and per-window control fields

	logic [4:0] mem_on;
	logic [1:0] io_on;
	logic [1:0] io_width_sel;
	logic [1:0] io_width_from_card;
	logic [1:0] io_shorten8;
	logic [1:0] io_extend16;

	assign mem_on = win_en_q[ciw_pkg::POS_MEM_WIN0_ON +: ciw_pkg::NUM_MEM_WIN];
	assign io_on[0] = win_en_q[ciw_pkg::POS_IO_WIN0_ON];
	assign io_on[1] = win_en_q[ciw_pkg::POS_IO_WIN1_ON];

	genvar gw;
	generate
		for (gw = 0; gw < ciw_pkg::NUM_IO_WIN; gw++) begin : g_io_field
			localparam int BASE = gw * ciw_pkg::IO_CTRL_STRIDE;
			assign io_width_sel[gw] = io_ctrl_q[BASE + ciw_pkg::POS_WIDTH_SEL];
			assign io_width_from_card[gw] = io_ctrl_q[BASE + ciw_pkg::POS_WIDTH_FROM_CARD];
			assign io_shorten8[gw] = io_ctrl_q[BASE + ciw_pkg::POS_SHORTEN8];
			assign io_extend16[gw] = io_ctrl_q[BASE + ciw_pkg::POS_EXTEND16];
		end
	endgenerate

	assign o_mem_win_on = mem_on;
	assign o_io_win_on = io_on;

	////////////////////////////////////////////////////////////////////////////////
	// Card width indication: pin is asynchronous, two flops before use

	logic wide_meta_q;
	logic wide_sync_q;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wide_meta_q <= 1'b0;
			wide_sync_q <= 1'b0;
		end else begin
			wide_meta_q <= ~i_card_io_wide_indication_n;
			wide_sync_q <= wide_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hit qualification: a window only hits while its enable is set

	logic [4:0] mem_hit_on;
	logic [1:0] io_hit_on;
	logic io_claimable;
	logic mem_claimable;

	assign mem_hit_on = i_mem_hit & mem_on;
	assign io_hit_on = i_io_hit & io_on;
	assign io_claimable = i_host_req && i_host_is_io && (io_hit_on != 2'b00);
	assign mem_claimable = i_host_req && !i_host_is_io && (mem_hit_on != 5'b00000);

	////////////////////////////////////////////////////////////////////////////////
	// Cycle length for the selected I/O window

	logic win_q;
	logic win_d;
	logic sel_wide;
	logic [7:0] sel_clocks;

	always_comb begin
		if (io_width_from_card[win_q]) begin
			sel_wide = wide_sync_q;
		end else begin
			sel_wide = io_width_sel[win_q];
		end
		if (sel_wide) begin
			if (io_extend16[win_q]) begin
				sel_clocks = ciw_pkg::CLOCKS_16_EXT;
			end else begin
				sel_clocks = ciw_pkg::CLOCKS_16_STD;
			end
		end else begin
			if (io_shorten8[win_q]) begin
				sel_clocks = ciw_pkg::CLOCKS_8_SHORT;
			end else begin
				sel_clocks = ciw_pkg::CLOCKS_8_STD;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Access sequencer

	ciw_timer_if tm ();

	ciw_cycle_timer u_timer (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.tm(tm)
	);

	ciw_pkg::ciw_state_e state_q;
	ciw_pkg::ciw_state_e state_d;
	logic claim_q;
	logic claim_d;
	logic is_io_q;
	logic is_io_d;
	logic wide_q;
	logic wide_d;

	// Requests arriving while an access is under way are dropped; the host
	// side is expected to hold off until o_host_done.
	always_comb begin
		state_d = state_q;
		claim_d = claim_q;
		win_d = win_q;
		is_io_d = is_io_q;
		wide_d = wide_q;
		tm.start = 1'b0;
		tm.load = 8'h00;
		case (state_q)
			ciw_pkg::ST_IDLE: begin
				if (io_claimable) begin
					claim_d = 1'b1;
					is_io_d = 1'b1;
					win_d = ~io_hit_on[0];
					wide_d = 1'b0;
					state_d = ciw_pkg::ST_DECODE;
				end else if (mem_claimable) begin
					claim_d = 1'b1;
					is_io_d = 1'b0;
					wide_d = 1'b0;
					tm.start = 1'b1;
					tm.load = ciw_pkg::CLOCKS_MEM;
					state_d = ciw_pkg::ST_RUN;
				end
			end
			ciw_pkg::ST_DECODE: begin
				// One clock for the card to answer the decoded address
				state_d = ciw_pkg::ST_SIZE;
			end
			ciw_pkg::ST_SIZE: begin
				wide_d = sel_wide;
				tm.start = 1'b1;
				tm.load = sel_clocks;
				state_d = ciw_pkg::ST_RUN;
			end
			ciw_pkg::ST_RUN: begin
				if (tm.expire) begin
					state_d = ciw_pkg::ST_DONE;
				end
			end
			ciw_pkg::ST_DONE: begin
				claim_d = 1'b0;
				state_d = ciw_pkg::ST_IDLE;
			end
			default: begin
				claim_d = 1'b0;
				state_d = ciw_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= ciw_pkg::ST_IDLE;
			claim_q <= 1'b0;
			win_q <= 1'b0;
			is_io_q <= 1'b0;
			wide_q <= 1'b0;
		end else begin
			state_q <= state_d;
			claim_q <= claim_d;
			win_q <= win_d;
			is_io_q <= is_io_d;
			wide_q <= wide_d;
		end
	end

	assign o_claim = claim_q;
	assign o_host_done = (state_q == ciw_pkg::ST_DONE);
	assign o_io_win_sel = win_q;
	assign o_card_strobe_n = ~(state_q == ciw_pkg::ST_RUN);
	assign o_card_is_io = is_io_q;
	assign o_card_wide = wide_q;

endmodule : ciw_window_ctrl

`default_nettype wire

/* logic/ciw_pkg.sv */
// Constants shared by the card window enable and I/O timing block
package ciw_pkg;

	// Register offsets inside the socket register space
	localparam logic [7:0] OFS_WINDOW_ENABLE = 8'h06;
	localparam logic [7:0] OFS_IO_WINDOW_CONTROL = 8'h07;

	// Values after reset
	localparam logic [7:0] WINDOW_ENABLE_RESET = 8'h00;
	localparam logic [7:0] IO_WINDOW_CONTROL_RESET = 8'h00;

	// Writable bits of the window enable register; bit 5 stays zero
	localparam logic [7:0] WINDOW_ENABLE_WMASK = 8'hDF;

	// Window enable register fields
	localparam int POS_MEM_WIN0_ON = 0;
	localparam int POS_IO_WIN0_ON = 6;
	localparam int POS_IO_WIN1_ON = 7;
	localparam int NUM_MEM_WIN = 5;
	localparam int NUM_IO_WIN = 2;

	// I/O window control fields, window 0 base; window 1 sits 4 bits higher
	localparam int POS_WIDTH_SEL = 0;
	localparam int POS_WIDTH_FROM_CARD = 1;
	localparam int POS_SHORTEN8 = 2;
	localparam int POS_EXTEND16 = 3;
	localparam int IO_CTRL_STRIDE = 4;

	// Timing: one ISA-equivalent cycle against the 20 MHz clock
	localparam int CLOCK_PERIOD_NS = 50;
	localparam int ISA_CYCLE_NS = 125;
	localparam int CLOCKS_PER_ISA = (ISA_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// Cycle lengths in ISA-equivalent cycles
	localparam int ISA_CYCLES_8_STD = 6;
	localparam int ISA_CYCLES_8_SHORT = 3;
	localparam int ISA_CYCLES_16_STD = 3;
	localparam int ISA_WAIT_STATES_16 = 1;
	localparam int ISA_CYCLES_MEM = 3;

	// Cycle lengths in clocks
	localparam logic [7:0] CLOCKS_8_STD = 8'(ISA_CYCLES_8_STD * CLOCKS_PER_ISA);
	localparam logic [7:0] CLOCKS_8_SHORT = 8'(ISA_CYCLES_8_SHORT * CLOCKS_PER_ISA);
	localparam logic [7:0] CLOCKS_16_STD = 8'(ISA_CYCLES_16_STD * CLOCKS_PER_ISA);
	localparam logic [7:0] CLOCKS_16_EXT =
		8'((ISA_CYCLES_16_STD + ISA_WAIT_STATES_16) * CLOCKS_PER_ISA);
	localparam logic [7:0] CLOCKS_MEM = 8'(ISA_CYCLES_MEM * CLOCKS_PER_ISA);

	// Access sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DECODE = 3'b001,
		ST_SIZE = 3'b010,
		ST_RUN = 3'b011,
		ST_DONE = 3'b100
	} ciw_state_e;

endpackage : ciw_pkg

/* logic/ciw_timer_if.sv */
// Carrier between the access sequencer and its cycle timer
`timescale 1ns/1ps
`default_nettype none

interface ciw_timer_if;
	logic start;
	logic [7:0] load;
	logic busy;
	logic expire;

	modport ctl (output start, output load, input busy, input expire);
	modport tmr (input start, input load, output busy, output expire);
endinterface : ciw_timer_if

`default_nettype wire

/* logic/ciw_cycle_timer.sv */
// Down counter that times one card access in clocks
`timescale 1ns/1ps
`default_nettype none

module ciw_cycle_timer (
	input wire logic i_clock, // System clock
	input wire logic i_rstn, // Asynchronous reset, active low
	ciw_timer_if.tmr tm // Start, length and status
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;

	////////////////////////////////////////////////////////////////////////////////
	// Busy for exactly load clocks after the start cycle
	always_comb begin
		cnt_d = cnt_q;
		if (tm.start) begin
			cnt_d = tm.load;
		end else if (cnt_q != 8'h00) begin
			cnt_d = cnt_q - 8'h01;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tm.busy = (cnt_q != 8'h00);
	assign tm.expire = (cnt_q == 8'h01);

endmodule : ciw_cycle_timer

`default_nettype wire

/* verification/ciw_card_model.sv */
// Card side model that drives the 16-bit I/O indication pin
`timescale 1ns/1ps
`default_nettype none
module ciw_card_model (
	input wire logic i_wide, // Card asks for 16-bit transfers
	output logic o_wide_n // Width pin, active low
);
	// Card address decode is static in this model, so the pin is a steady level
	assign o_wide_n = !i_wide;
endmodule : ciw_card_model
`default_nettype wire

/* verification/ciw_window_ctrl_monitor.sv */
// Port checker of the card window enable and I/O timing block
`timescale 1ns/1ps
`default_nettype none
module ciw_window_ctrl_monitor (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_host_req,
	input wire logic i_host_is_io,
	input wire logic [4:0] i_mem_hit,
	input wire logic [1:0] i_io_hit,
	input wire logic o_claim,
	input wire logic o_host_done,
	input wire logic o_io_win_sel,
	input wire logic [4:0] o_mem_win_on,
	input wire logic [1:0] o_io_win_on,
	input wire logic i_card_io_wide_indication_n,
	input wire logic o_card_strobe_n,
	input wire logic o_card_is_io,
	input wire logic o_card_wide
);
	logic [7:0] ctl_q, ctl_d, cnt_q, cnt_d;
	logic take, pick1, ex, sh, fc, ws;
	assign take = i_host_req && !o_claim && (i_host_is_io ? |(i_io_hit & o_io_win_on)
		: |(i_mem_hit & o_mem_win_on));
	assign pick1 = !(i_io_hit[0] && o_io_win_on[0]);
	assign {ex, sh, fc, ws} = o_io_win_sel ? ctl_q[7:4] : ctl_q[3:0];
	always_comb begin
		ctl_d = i_reg_wr && i_reg_addr == ciw_pkg::OFS_IO_WINDOW_CONTROL ? i_reg_wdata : ctl_q;
		// Clocks since the request was taken; zero while idle
		cnt_d = take ? 8'h01 : (o_host_done || cnt_q == 8'h00 ? 8'h00 : cnt_q + 8'h01);
	end
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			ctl_q <= 8'h00;
			cnt_q <= 8'h00;
		end else begin
			ctl_q <= ctl_d;
			cnt_q <= cnt_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	sequence s_io_take; take && i_host_is_io; endsequence
	sequence s_en_wr; i_reg_wr && i_reg_addr == ciw_pkg::OFS_WINDOW_ENABLE; endsequence
	property p_rst; $rose(i_rstn) |-> {o_io_win_on, o_mem_win_on, o_card_wide} == 8'h00; endproperty
	a_rst: assert property (p_rst)
		else $error("state not clear after reset");
	property p_nclm; i_host_req && !o_claim && !take |=> !o_claim; endproperty
	a_nclm: assert property (p_nclm)
		else $error("disabled window claimed");
	property p_en; logic [7:0] d;
		(s_en_wr, d = i_reg_wdata) |=> {o_io_win_on, o_mem_win_on} == {d[7:6], d[4:0]}; endproperty
	a_en: assert property (p_en)
		else $error("enables differ from write");
	property p_en_rd; logic [7:0] e;
		(i_reg_rd && i_reg_addr == ciw_pkg::OFS_WINDOW_ENABLE, e = {o_io_win_on, 1'b0, o_mem_win_on})
		|=> o_reg_rdata == e; endproperty
	a_en_rd: assert property (p_en_rd)
		else $error("enable readback wrong");
	property p_sel; s_io_take |=> o_claim && o_io_win_sel == $past(pick1); endproperty
	a_sel: assert property (p_sel)
		else $error("wrong I/O window taken");
	property p_wid; s_io_take |-> ##3 o_card_wide == (fc ? !i_card_io_wide_indication_n : ws);
	endproperty
	a_wid: assert property (p_wid)
		else $error("I/O width wrong");
	property p_l16; o_host_done && o_card_is_io && o_card_wide
		|-> cnt_q == 8'h03 + (ex ? ciw_pkg::CLOCKS_16_EXT : ciw_pkg::CLOCKS_16_STD); endproperty
	a_l16: assert property (p_l16)
		else $error("16-bit cycle length wrong");
	property p_l8; o_host_done && o_card_is_io && !o_card_wide
		|-> cnt_q == 8'h03 + (sh ? ciw_pkg::CLOCKS_8_SHORT : ciw_pkg::CLOCKS_8_STD); endproperty
	a_l8: assert property (p_l8)
		else $error("8-bit cycle length wrong");
	property p_lmem; o_host_done && !o_card_is_io |-> cnt_q == 8'h01 + ciw_pkg::CLOCKS_MEM;
	endproperty
	a_lmem: assert property (p_lmem)
		else $error("memory cycle length wrong");
	property p_stb_idle; !o_claim |-> o_card_strobe_n; endproperty
	a_stb_idle: assert property (p_stb_idle)
		else $error("card strobe outside a claimed access");
	property p_stb_end; o_host_done |-> o_card_strobe_n && !$past(o_card_strobe_n); endproperty
	a_stb_end: assert property (p_stb_end)
		else $error("card strobe not released at done");
endmodule : ciw_window_ctrl_monitor
bind ciw_window_ctrl ciw_window_ctrl_monitor i_mon (.*);
`default_nettype wire

/* verification/tb_ciw_window_ctrl.sv */
// Self-checking bench of the card window enable and I/O timing block
`timescale 1ns/1ps
`default_nettype none
module tb_ciw_window_ctrl;
	logic i_clock, i_rstn, i_reg_wr, i_reg_rd, i_host_req, i_host_is_io, card_wide, w16;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, len, ctl;
	logic [4:0] i_mem_hit, o_mem_win_on;
	logic [1:0] i_io_hit, o_io_win_on;
	logic o_claim, o_host_done, o_io_win_sel, o_card_strobe_n, o_card_is_io, o_card_wide;
	logic i_card_io_wide_indication_n;
	logic [3:0] nib;
	int err_total, checked;
	ciw_card_model i_card (.i_wide(card_wide), .o_wide_n(i_card_io_wide_indication_n));
	ciw_window_ctrl i_dut (.i_clock, .i_rstn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
		.o_reg_rdata, .i_host_req, .i_host_is_io, .i_mem_hit, .i_io_hit, .o_claim, .o_host_done,
		.o_io_win_sel, .o_mem_win_on, .o_io_win_on, .i_card_io_wide_indication_n,
		.o_card_strobe_n, .o_card_is_io, .o_card_wide);
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize();
		if (err_total == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	task automatic do_reset();
		@(negedge i_clock);
		i_rstn = 1'b0;
		repeat (4) @(negedge i_clock);
		i_rstn = 1'b1;
	endtask : do_reset
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clock);
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(negedge i_clock);
		i_reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge i_clock);
		i_reg_rd = 1'b1;
		i_reg_addr = a;
		@(negedge i_clock);
		i_reg_rd = 1'b0;
		chk(o_reg_rdata, exp);
	endtask : rd
	// A zero length means the request must be left unclaimed
	task automatic acc(input logic io, input logic [4:0] m, input logic [1:0] h,
		input logic [7:0] n_exp, input logic [1:0] ws);
		int n;
		int lo;
		@(negedge i_clock);
		i_host_req = 1'b1;
		i_host_is_io = io;
		i_mem_hit = m;
		i_io_hit = h;
		@(negedge i_clock);
		i_host_req = 1'b0;
		n = 1;
		lo = 0;
		chk({7'h00, o_claim}, {7'h00, n_exp != 8'h00});
		while (n_exp != 8'h00 && o_host_done !== 1'b1 && n < 40) begin
			if (o_card_strobe_n === 1'b0) lo++;
			@(negedge i_clock);
			n++;
		end
		if (n == 40) begin
			err_total++;
			summarize();
		end
		if (n_exp != 8'h00) chk(8'(n), n_exp);
		if (io && n_exp != 8'h00) chk({6'h00, o_card_wide, o_io_win_sel}, {6'h00, ws});
		if (n_exp != 8'h00) chk(8'(lo), n_exp - (io ? 8'h03 : 8'h01));
		if (n_exp != 8'h00) chk({7'h00, o_card_is_io}, {7'h00, io});
		if (n_exp == 8'h00) chk({7'h00, o_card_strobe_n}, 8'h01);
		@(negedge i_clock);
	endtask : acc
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_rstn = 1'b0;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_addr = 8'h00;
		i_reg_wdata = 8'h00;
		i_host_req = 1'b0;
		i_host_is_io = 1'b0;
		i_mem_hit = 5'h00;
		i_io_hit = 2'h0;
		card_wide = 1'b0;
		err_total = 0;
		checked = 0;
		do_reset();
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h00);
		rd(8'h05, 8'h00);
		acc(1'b0, 5'h1F, 2'h0, 8'h00, 2'h0);
		acc(1'b1, 5'h00, 2'h3, 8'h00, 2'h0);
		wr(8'h06, 8'hFF);
		rd(8'h06, 8'hDF);
		wr(8'h05, 8'h00);
		rd(8'h06, 8'hDF);
		for (int b = 0; b < 8; b++) begin
			wr(8'h06, 8'h01 << b);
			rd(8'h06, (8'h01 << b) & 8'hDF);
			len = b < 5 ? 8'h01 + ciw_pkg::CLOCKS_MEM : 8'h00;
			acc(1'b0, 5'h1F, 2'h0, len, 2'h0);
			acc(1'b0, ~(5'h01 << b), 2'h0, 8'h00, 2'h0);
			len = b > 5 ? 8'h03 + ciw_pkg::CLOCKS_8_STD : 8'h00;
			acc(1'b1, 5'h00, 2'h3, len, {1'b0, b == 7});
		end
		// Other window gets the inverted nibble so cross-window leaks show up
		for (int k = 0; k < 64; k++) begin
			nib = k[3:0];
			card_wide = k[4];
			ctl = k[5] ? {nib, ~nib} : {~nib, nib};
			wr(8'h06, k[5] ? 8'h80 : 8'h40);
			wr(8'h07, ctl);
			rd(8'h07, ctl);
			w16 = nib[1] ? card_wide : nib[0];
			len = 8'h03 + (w16 ? (nib[3] ? ciw_pkg::CLOCKS_16_EXT : ciw_pkg::CLOCKS_16_STD)
				: (nib[2] ? ciw_pkg::CLOCKS_8_SHORT : ciw_pkg::CLOCKS_8_STD));
			acc(1'b1, 5'h00, 2'h3, len, {w16, k[5]});
		end
		do_reset();
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h00);
		summarize();
	end
endmodule : tb_ciw_window_ctrl
`default_nettype wire
